// File: logic/scr_pkg.sv
package scr_pkg;
  // register addresses on the plain port
  localparam logic [3:0] ADDR_CFG_LO = 4'h0;
  localparam logic [3:0] ADDR_CFG_HI = 4'h1;
  localparam logic [3:0] ADDR_OPTS   = 4'h2;
  // field positions in the 64-bit register
  localparam int BIT_SSE    = 62;
  localparam int BIT_ENC    = 49;
  localparam int BIT_GRAN   = 48;
  localparam int BIT_SYSC   = 44;
  localparam int BIT_TRAN   = 43;
  localparam int BIT_TP2    = 41;
  localparam int BIT_RND    = 40;
  localparam int BIT_HYP    = 38;
  localparam int BIT_ACC    = 37;
  localparam int BIT_AS0    = 36;
  localparam int BIT_VOFF   = 35;
  localparam int BIT_TME    = 34;
  localparam int BIT_DLY_LO = 30;
  localparam int BIT_DLYEN  = 29;
  localparam int BIT_CNTO   = 28;
  // writable field mask; reserved bits 63,61:50,47:45,42,27:0 stay zero
  localparam logic [63:0] WR_MASK = 64'h4003_1bff_f000_0000;
  // option bits register (opts) layout
  localparam int OPT_EL3  = 0;
  localparam int OPT_RME  = 1;
  // exception classes, syndrome, wait delay base and redirect offset
  localparam logic [5:0]  EC_SYSREG = 6'h18;
  localparam logic [5:0]  EC_LS64   = 6'h0a;
  localparam logic [5:0]  EC_WFX    = 6'h01;
  localparam logic [24:0] ISS_AS0   = 25'h0000001;
  localparam int          DLY_BASE  = 8;
  localparam logic [11:0] NV_OFFSET = 12'h900;
  // access classes from the execution logic
  typedef enum logic [3:0] {
    SCR_ACC_NONE = 4'h0, SCR_ACC_ENC = 4'h1, SCR_ACC_SYSC = 4'h2,
    SCR_ACC_TRAN = 4'h3, SCR_ACC_TP2 = 4'h4, SCR_ACC_RND = 4'h5,
    SCR_ACC_HYP = 4'h6, SCR_ACC_ACC = 4'h7, SCR_ACC_AS0 = 4'h8,
    SCR_ACC_VOFF = 4'h9, SCR_ACC_TME = 4'ha, SCR_ACC_CNTO = 4'hb,
    SCR_ACC_PART = 4'hc, SCR_ACC_SELF = 4'hd
  } scr_acc_t;
  // outcome kinds
  typedef enum logic [2:0] {
    SCR_RES_OK = 3'h0, SCR_RES_EL3 = 3'h1, SCR_RES_EL2 = 3'h3,
    SCR_RES_UNDEF = 3'h2, SCR_RES_NVMEM = 3'h6, SCR_RES_ALT = 3'h7
  } scr_res_t;
  // wait trap delay sequencer states
  typedef enum logic [1:0] {
    SCR_W_IDLE = 2'b00, SCR_W_COUNT = 2'b01, SCR_W_FIRE = 2'b11
  } scr_wst_t;
endpackage

// File: logic/scr_trap_ctrl.sv
// Implementation choices: the strobed register port and the placing of the registers.
module scr_trap_ctrl
  import scr_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [31:0]      rdata,
  input  wire logic        acc_valid,
  input  wire logic [3:0]  acc_kind,
  input  wire logic [1:0]  acc_el,
  input  wire logic        acc_write,
  input  wire logic        acc_hi_prio,
  input  wire logic        acc_low_trap,
  input  wire logic        el2_enabled,
  input  wire logic        el2_part_trap,
  input  wire logic [2:0]  nv_bits,
  input  wire logic        e2h,
  input  wire logic        lower_trap,
  input  wire logic        halted,
  input  wire logic        secure_debug_disable,
  input  wire logic        gran_fault,
  input  wire logic        wait_req,
  output logic             res_valid,
  output logic [2:0]       res_kind,
  output logic [5:0]       res_ec,
  output logic [24:0]      res_iss,
  output logic [11:0]      res_nv_off,
  output logic             res_zero,
  output logic             gran_to_el3,
  output logic             wait_trap,
  output logic [5:0]       wait_ec
);
  //////////////////////////////////////////////////////////////////////
  // register file
  logic [63:0] cfg_r, cfg_nxt;
  logic [1:0]  opt_r, opt_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [63:0] eff;

  // effective value masks the security ext bit without realm
  always_comb begin
    eff = cfg_r;
    if (!opt_r[OPT_RME]) begin
      eff[BIT_SSE] = 1'b0;
    end
  end

  // writes keep reserved positions at zero
  always_comb begin
    cfg_nxt   = cfg_r;
    opt_nxt   = opt_r;
    rdata_nxt = 32'h0;
    if (wr) begin
      unique case (addr)
        ADDR_CFG_LO: cfg_nxt[31:0]  = wdata & WR_MASK[31:0];
        ADDR_CFG_HI: cfg_nxt[63:32] = wdata & WR_MASK[63:32];
        ADDR_OPTS:   opt_nxt        = wdata[1:0];
        default:     cfg_nxt        = cfg_r;
      endcase
    end
    if (rd) begin
      unique case (addr)
        ADDR_CFG_LO: rdata_nxt = eff[31:0];
        ADDR_CFG_HI: rdata_nxt = eff[63:32];
        ADDR_OPTS:   rdata_nxt = {30'h0, opt_r};
        default:     rdata_nxt = 32'h0;
      endcase
    end
  end

  // fields hold no defined reset value architecturally; zero chosen
  // only so simulation starts from known state
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cfg_r   <= 64'h0;
      opt_r   <= 2'b01;
      rdata_r <= 32'h0;
    end else begin
      cfg_r   <= cfg_nxt;
      opt_r   <= opt_nxt;
      rdata_r <= rdata_nxt;
    end
  end
  assign rdata = rdata_r;

  //////////////////////////////////////////////////////////////////////
  // access decode
  function automatic logic is_lower(input logic [1:0] el,
                                    input logic       e1,
                                    input logic       e2);
    is_lower = (el == 2'd1 && e1) || (el == 2'd2 && e2);
  endfunction

  scr_res_t    kind_c;
  logic [5:0]  ec_c;
  logic [24:0] iss_c;
  logic        zero_c;
  logic        l3t;

  always_comb begin
    kind_c = SCR_RES_OK;
    ec_c   = EC_SYSREG;
    iss_c  = 25'h0;
    zero_c = 1'b0;
    l3t    = 1'b0;
    unique case (acc_kind)
      SCR_ACC_ENC: begin
        l3t    = is_lower(acc_el, 1'b0, 1'b1) && !eff[BIT_ENC];
        zero_c = !eff[BIT_ENC] && acc_el != 2'd3;
      end
      SCR_ACC_SYSC: begin
        l3t    = is_lower(acc_el, 1'b1, 1'b1) && !eff[BIT_SYSC];
        zero_c = !eff[BIT_SYSC];
      end
      SCR_ACC_TRAN: begin
        l3t    = is_lower(acc_el, 1'b1, 1'b1) && !eff[BIT_TRAN];
        zero_c = !eff[BIT_TRAN];
      end
      SCR_ACC_TP2:
        l3t = acc_el != 2'd3 && !eff[BIT_TP2];
      SCR_ACC_RND:
        l3t = acc_el != 2'd3 && eff[BIT_RND];
      SCR_ACC_HYP: begin
        l3t    = acc_el == 2'd2 && !eff[BIT_HYP];
        zero_c = !eff[BIT_HYP];
      end
      SCR_ACC_ACC: // fine-grained EL2 trap comes in on acc_low_trap
        l3t = is_lower(acc_el, 1'b1, 1'b1) && !eff[BIT_ACC];
      SCR_ACC_AS0: begin
        l3t   = acc_el != 2'd3 && !eff[BIT_AS0];
        ec_c  = EC_LS64;
        iss_c = ISS_AS0;
      end
      SCR_ACC_VOFF: begin
        l3t    = acc_el == 2'd2 && !eff[BIT_VOFF];
        zero_c = !eff[BIT_VOFF];
      end
      SCR_ACC_CNTO: begin
        l3t    = acc_el == 2'd2 && !eff[BIT_CNTO];
        zero_c = !eff[BIT_CNTO] && acc_el != 2'd3;
      end
      SCR_ACC_TME:
        if (acc_el != 2'd3 && !eff[BIT_TME]) begin
          kind_c = SCR_RES_UNDEF;
        end
      default: l3t = 1'b0;
    endcase
    if (l3t) begin
      kind_c = SCR_RES_EL3;
    end
    // lower level or fine-grained traps win over EL3 traps for the ACC class at any level, and for AS0 below EL2
    if (l3t && acc_low_trap && acc_el != 2'd2 &&
        (acc_kind == 4'(SCR_ACC_AS0) || acc_kind == 4'(SCR_ACC_ACC))) begin
      kind_c = SCR_RES_EL2;
    end else if (l3t && acc_low_trap && acc_kind == 4'(SCR_ACC_ACC)) begin
      kind_c = SCR_RES_EL2;
    end
    // partition register write decode
    if (acc_kind == 4'(SCR_ACC_PART) && acc_write) begin
      if (acc_el == 2'd0) begin
        kind_c = SCR_RES_UNDEF;
      end else if (acc_el != 2'd3 && lower_trap) begin
        kind_c = (halted && secure_debug_disable) ? SCR_RES_UNDEF : SCR_RES_EL3;
      end else if (acc_el == 2'd1 && el2_enabled && el2_part_trap) begin
        kind_c = SCR_RES_EL2;
      end else if (acc_el == 2'd1 && el2_enabled && nv_bits == 3'b111) begin
        kind_c = SCR_RES_NVMEM;
      end else if (acc_el == 2'd2 && e2h) begin
        kind_c = SCR_RES_ALT;
      end
    end
    if (acc_kind == 4'(SCR_ACC_SELF) && acc_el != 2'd3) begin
      kind_c = SCR_RES_UNDEF;
    end
    if (!opt_r[OPT_EL3] && acc_kind == 4'(SCR_ACC_SELF)) begin
      kind_c = SCR_RES_UNDEF;
    end
    // a higher priority exception suppresses this block's traps
    if (acc_hi_prio) begin
      kind_c = SCR_RES_OK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // result registers
  logic        rv_r, gr_r, wt_r, rz_r;
  logic [2:0]  rk_r;
  logic [5:0]  re_r;
  logic [24:0] ri_r;
  logic [11:0] rn_r;
  logic [5:0]  we_r;
  logic        go_c;

  scr_wait_delay u_wait (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .wait_req(wait_req),
    .dly_en  (eff[BIT_DLYEN]),
    .dly_sel (eff[BIT_DLY_LO+3:BIT_DLY_LO]),
    .trap_go (go_c)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rv_r <= 1'b0;
      rk_r <= 3'h0;
      re_r <= 6'h0;
      ri_r <= 25'h0;
      rn_r <= 12'h0;
      rz_r <= 1'b0;
      gr_r <= 1'b0;
      wt_r <= 1'b0;
      we_r <= EC_WFX;
    end else begin
      rv_r <= acc_valid;
      rk_r <= acc_valid ? 3'(kind_c) : 3'h0;
      re_r <= ec_c;
      ri_r <= iss_c;
      rn_r <= (kind_c == SCR_RES_NVMEM) ? NV_OFFSET : 12'h0;
      rz_r <= acc_valid && zero_c;
      gr_r <= gran_fault && eff[BIT_GRAN] && acc_el != 2'd3;
      wt_r <= go_c;
      we_r <= EC_WFX;
    end
  end
  assign res_valid   = rv_r;
  assign res_kind    = rk_r;
  assign res_ec      = re_r;
  assign res_iss     = ri_r;
  assign res_nv_off  = rn_r;
  assign res_zero    = rz_r;
  assign gran_to_el3 = gr_r;
  assign wait_trap   = wt_r;
  // registered so every output leaves a flop, even a fixed class
  assign wait_ec     = we_r;

  //////////////////////////////////////////////////////////////////////
  a_gran_route: assert property (@(posedge clk_sys) disable iff (!arst_n)
    gran_fault && acc_el != 2'd3 |=> gran_to_el3 == $past(eff[BIT_GRAN]))
    else $error("granule route wrong");
  a_sse_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rd && addr == ADDR_CFG_HI && !opt_r[OPT_RME] |=> !rdata[30])
    else $error("security ext bit not zero");
  a_hi_prio: assert property (@(posedge clk_sys) disable iff (!arst_n)
    acc_valid && acc_hi_prio |=> res_kind == 3'(SCR_RES_OK))
    else $error("trap beat higher priority");
  a_tme_undef: assert property (@(posedge clk_sys) disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_TME) && acc_el != 2'd3 &&
    !eff[BIT_TME] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_UNDEF))
    else $error("transact not undefined");
  a_as0_code: assert property (@(posedge clk_sys) disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_AS0) |=>
    res_ec == EC_LS64 && res_iss == ISS_AS0)
    else $error("status store syndrome");
  a_nv_redir: assert property (@(posedge clk_sys) disable iff (!arst_n)
    res_kind == 3'(SCR_RES_NVMEM) |-> res_nv_off == NV_OFFSET)
    else $error("redirect offset wrong");
  a_tp2_trap: assert property (@(posedge clk_sys) disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_TP2) && acc_el == 2'd0 &&
    !eff[BIT_TP2] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL3))
    else $error("thread pointer not trapped");
  a_dly_min: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(wait_req) && eff[BIT_DLYEN] |=> !go_c [*8])
    else $error("wait trap too early");
  a_reserved: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (cfg_r & ~WR_MASK) == 64'h0)
    else $error("reserved bit set");

  //////////////////////////////////////////////////////////////////////
  // per-class trap checks; hi prio excluded from the res_kind checks since it forces res_kind to OK
  a_enc_trap: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_ENC) && acc_el == 2'd2 &&
    !eff[BIT_ENC] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL3))
    else $error("enc context not trapped");
  a_sysc_zero: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_SYSC) && !eff[BIT_SYSC]
    |=> res_zero)
    else $error("ext sysctl not zero");
  a_tran_trap: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_TRAN) && acc_el == 2'd1 &&
    !eff[BIT_TRAN] && !acc_hi_prio |=>
    res_kind == 3'(SCR_RES_EL3) && res_ec == EC_SYSREG)
    else $error("ext transl not trapped");
  a_rnd_trap: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_RND) && acc_el == 2'd0 &&
    eff[BIT_RND] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL3))
    else $error("random read not trapped");
  a_hyp_trap: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_HYP) && acc_el == 2'd2 &&
    !eff[BIT_HYP] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL3))
    else $error("ext hyp config not trapped");
  a_acc_fine: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_ACC) && acc_el == 2'd1 &&
    acc_low_trap && !eff[BIT_ACC] && !acc_hi_prio |=>
    res_kind == 3'(SCR_RES_EL2))
    else $error("fine trap lost priority");
  a_voff_zero: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_VOFF) && !eff[BIT_VOFF]
    |=> res_zero)
    else $error("voffset not zero");
  a_cnto_trap: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_CNTO) && acc_el == 2'd2 &&
    !eff[BIT_CNTO] && !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL3))
    else $error("counter offset not trapped");
  a_part_el2: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_PART) && acc_write &&
    acc_el == 2'd1 && !lower_trap && el2_enabled && el2_part_trap &&
    !acc_hi_prio |=> res_kind == 3'(SCR_RES_EL2))
    else $error("partition write not to EL2");
  a_self_undef: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    acc_valid && acc_kind == 4'(SCR_ACC_SELF) && !opt_r[OPT_EL3] &&
    !acc_hi_prio |=> res_kind == 3'(SCR_RES_UNDEF))
    else $error("access without EL3 defined");
  a_wait_ec: assert property (@(posedge clk_sys)
    disable iff (!arst_n)
    wait_trap |-> wait_ec == EC_WFX)
    else $error("wait trap class wrong");
endmodule

// File: logic/scr_wait_delay.sv
module scr_wait_delay
  import scr_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       wait_req,
  input  wire logic       dly_en,
  input  wire logic [3:0] dly_sel,
  output logic            trap_go
);
  scr_wst_t    st_r, st_nxt;
  logic [23:0] cnt_r, cnt_nxt;
  logic [23:0] target;

  // minimum delay is 2^(field+8) cycles when enabled
  always_comb begin
    target = 24'h1 << (5'(dly_sel) + 5'(DLY_BASE));
    st_nxt  = st_r;
    cnt_nxt = cnt_r;
    trap_go = 1'b0;
    unique case (st_r)
      SCR_W_IDLE: begin
        cnt_nxt = 24'h1;
        if (wait_req) begin
          st_nxt = dly_en ? SCR_W_COUNT : SCR_W_FIRE;
        end
      end
      SCR_W_COUNT: begin
        cnt_nxt = cnt_r + 24'h1;
        if (!wait_req) begin
          st_nxt = SCR_W_IDLE;
        end else if (cnt_r >= target) begin
          st_nxt = SCR_W_FIRE;
        end
      end
      SCR_W_FIRE: begin
        trap_go = 1'b1;
        st_nxt  = SCR_W_IDLE;
      end
      default: st_nxt = SCR_W_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r  <= SCR_W_IDLE;
      cnt_r <= 24'h0;
    end else begin
      st_r  <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// File: verification/scr_core_model.sv
module scr_core_model (
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic       gf,
  input  wire logic [3:0] k,
  input  wire logic [1:0] el,
  input  wire logic       w,
  output logic            acc_valid,
  output logic            gran_fault,
  output logic [3:0]      acc_kind,
  output logic [1:0]      acc_el,
  output logic            acc_write
);
  timeunit 1ns;
  timeprecision 100ps;
  // one request cycle per command; fields scramble when idle so the
  // block never leans on a stale class
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_valid  <= 1'b0;
      gran_fault <= 1'b0;
      acc_kind   <= 4'h0;
      acc_el     <= 2'h0;
      acc_write  <= 1'b0;
    end else begin
      acc_valid  <= go && !gf;
      gran_fault <= go && gf;
      acc_kind   <= go ? k : ~acc_kind;
      acc_el     <= go ? el : ~acc_el;
      acc_write  <= go ? w : ~acc_write;
    end
  end
endmodule

// File: verification/tb_top.sv
module tb_top
  import scr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, arst_n, wr, rd, go, cg, cw;
  logic        acc_hi_prio, acc_low_trap, el2_enabled, el2_part_trap;
  logic        e2h, lower_trap, halted, secure_debug_disable, wait_req, res_valid;
  logic        acc_valid, gran_fault, acc_write, res_zero;
  logic        gran_to_el3, wait_trap;
  logic [3:0]  addr, ck, acc_kind;
  logic [31:0] wdata, rdata;
  logic [2:0]  nv_bits, res_kind;
  logic [1:0]  ce, acc_el, opts;
  logic [5:0]  res_ec, wait_ec;
  logic [24:0] res_iss;
  logic [11:0] res_nv_off;
  logic [63:0] cfg;
  int          fails, total_checks, cyc;

  scr_trap_ctrl i_dut (.*);
  scr_core_model i_core (.clk_sys(clk_sys), .arst_n(arst_n), .go(go),
    .gf(cg), .k(ck), .el(ce), .w(cw), .acc_valid(acc_valid),
    .gran_fault(gran_fault), .acc_kind(acc_kind), .acc_el(acc_el),
    .acc_write(acc_write));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // hang guard, well above the longest wait delay run
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task automatic finish_test();
    if (fails == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  // read data only stands in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    chk("rdata", e, rdata);
  endtask
  task automatic set_opts(input logic [1:0] o);
    wreg(ADDR_OPTS, {30'h0, o});
    opts = o;
  endtask
  // shadow keeps only writable bits; ss bit needs the realm option
  task automatic set_cfg(input logic [63:0] v);
    wreg(ADDR_CFG_LO, v[31:0]);
    wreg(ADDR_CFG_HI, v[63:32]);
    cfg = v & WR_MASK;
    if (!opts[1]) cfg[BIT_SSE] = 1'b0;
  endtask
  // {dont_care, kind, ec, zero}; table is {enable bit, el2/el1/el0, zero}
  function automatic logic [10:0] exp_res(input logic [3:0] k,
                                          input logic [1:0] el);
    logic [9:0] t;
    logic       on, tr, lo, d;
    logic [2:0] r;
    lo = el != 2'd3;
    r = SCR_RES_OK;
    d = lo && acc_hi_prio;
    case (k)
      SCR_ACC_ENC:  t = {6'(BIT_ENC), 4'b1001};
      SCR_ACC_SYSC: t = {6'(BIT_SYSC), 4'b1101};
      SCR_ACC_TRAN: t = {6'(BIT_TRAN), 4'b1101};
      SCR_ACC_TP2:  t = {6'(BIT_TP2), 4'b1110};
      SCR_ACC_RND:  t = {6'(BIT_RND), 4'b1110};
      SCR_ACC_HYP:  t = {6'(BIT_HYP), 4'b1001};
      SCR_ACC_ACC:  t = {6'(BIT_ACC), 4'b1100};
      SCR_ACC_AS0:  t = {6'(BIT_AS0), 4'b1110};
      SCR_ACC_VOFF: t = {6'(BIT_VOFF), 4'b1001};
      SCR_ACC_TME:  t = {6'(BIT_TME), 4'b1110};
      SCR_ACC_CNTO: t = {6'(BIT_CNTO), 4'b1001};
      default:      t = '0;
    endcase
    on = cfg[t[9:4]] ^ (k == SCR_ACC_RND);
    tr = lo && t[int'(el) + 1] && !on;
    if (tr) r = k == SCR_ACC_TME ? SCR_RES_UNDEF : SCR_RES_EL3;
    // a lower-level fine trap outranks ours
    if (tr && acc_low_trap && (k == SCR_ACC_ACC || k == SCR_ACC_AS0 && el < 2))
      d = 1'b1;
    if (k == SCR_ACC_PART) begin
      if (el == 2'd0) r = SCR_RES_UNDEF;
      else if (lo && lower_trap)
        r = halted && secure_debug_disable ? SCR_RES_UNDEF : SCR_RES_EL3;
      else if (el == 2'd1 && el2_enabled && el2_part_trap) r = SCR_RES_EL2;
      else if (el == 2'd1 && el2_enabled && nv_bits == 3'b111)
        r = SCR_RES_NVMEM;
      else if (el == 2'd2 && e2h) r = SCR_RES_ALT;
    end
    if (k == SCR_ACC_SELF && !(el == 2'd3 && opts[0])) r = SCR_RES_UNDEF;
    return {d, r, k == SCR_ACC_AS0 ? EC_LS64 : EC_SYSREG, lo && t[0] && !on};
  endfunction
  task automatic access(input logic [3:0] k, input logic [1:0] el,
                        input logic g);
    logic [10:0] x;
    @(posedge clk_sys);
    go <= 1'b1;
    cg <= g;
    ck <= k;
    ce <= el;
    cw <= k == SCR_ACC_PART || 1'($urandom);
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    x = exp_res(k, el);
    if (g) begin
      chk("gran", cfg[BIT_GRAN] && lo_el(el), gran_to_el3);
      return;
    end
    chk("valid", 1, res_valid);
    if (x[10]) begin
      chk("no_el3", 0, res_kind == SCR_RES_EL3);
      return;
    end
    chk("kind", x[9:7], res_kind);
    if (x[9:7] == SCR_RES_EL3 || x[9:7] == SCR_RES_EL2)
      chk("ec", x[6:1], res_ec);
    if (k == SCR_ACC_AS0 && x[9:7] == SCR_RES_EL3)
      chk("iss", ISS_AS0, res_iss);
    if (x[9:7] == SCR_RES_NVMEM)
      chk("nv_off", NV_OFFSET, res_nv_off);
    if (lo_el(el)) chk("zero", x[0], res_zero);
  endtask
  function automatic logic lo_el(input logic [1:0] el);
    return el != 2'd3;
  endfunction
  // delay measured from the wait request to the trap pulse
  task automatic wchk(input logic [3:0] f, input logic en);
    int n;
    int lo;
    n = 0;
    lo = en ? 1 << (f + 8) : 1;
    set_cfg({30'h0, f, en, 29'h0});
    @(posedge clk_sys);
    wait_req <= 1'b1;
    do begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (wait_trap !== 1'b1 && n < 9000);
    chk("wait_ec", EC_WFX, wait_ec);
    chk("wait_dly", 1, n >= lo && n <= lo + 8);
    @(posedge clk_sys);
    wait_req <= 1'b0;
  endtask
  ////////////////////////////////////////
  initial begin
    int n;
    {wr, rd, go, cg, cw, acc_hi_prio, acc_low_trap, wait_req} = '0;
    {el2_enabled, el2_part_trap, e2h, lower_trap, halted, secure_debug_disable} = '0;
    {nv_bits, addr, wdata, ck, ce, fails, total_checks, cyc} = '0;
    {cfg, opts} = {64'h0, 2'b01};
    arst_n = 1'b0;
    void'($urandom(32'hdeaf));
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    rchk(ADDR_CFG_LO, 32'h0);
    rchk(ADDR_CFG_HI, 32'h0);
    rchk(ADDR_OPTS, 32'h1);
    wreg(ADDR_CFG_HI, 32'hffff_ffff);
    rchk(ADDR_CFG_HI, 32'h0003_1bff);
    wreg(ADDR_CFG_LO, 32'hffff_ffff);
    rchk(ADDR_CFG_LO, 32'hf000_0000);
    wreg(4'h7, 32'hffff_ffff);
    rchk(4'h7, 32'h0);
    set_opts(2'b11);
    set_cfg('1);
    rchk(ADDR_CFG_HI, 32'h4003_1bff);
    set_opts(2'b00);
    access(SCR_ACC_SELF, 2'd3, 1'b0);
    set_opts(2'b01);
    // every class at every level, all enables clear then all set
    for (int v = 0; v < 2; v++) begin
      set_cfg(v ? '1 : '0);
      for (int j = 0; j < 56; j++) access(4'(j >> 2), 2'(j), 1'b0);
    end
    el2_enabled <= 1'b1;
    nv_bits <= 3'b111;
    access(SCR_ACC_PART, 2'd1, 1'b0);
    el2_part_trap <= 1'b1;
    access(SCR_ACC_PART, 2'd1, 1'b0);
    {lower_trap, e2h} <= 2'b01;
    access(SCR_ACC_PART, 2'd2, 1'b0);
    {lower_trap, halted, secure_debug_disable} <= 3'b111;
    access(SCR_ACC_PART, 2'd2, 1'b0);
    // random mix, one in eight is a granule fault
    for (int i = 0; i < 400; i++) begin
      if (i % 16 == 0) set_cfg({$urandom, $urandom});
      {el2_enabled, el2_part_trap, e2h, lower_trap, halted, secure_debug_disable} <= 6'($urandom);
      nv_bits <= 3'($urandom);
      acc_hi_prio <= $urandom_range(7) == 0;
      acc_low_trap <= 1'($urandom);
      access(4'($urandom_range(13)), 2'($urandom), $urandom_range(7) == 0);
    end
    wchk(4'd0, 1'b1);
    wchk(4'd1, 1'b1);
    wchk(4'd2, 1'b1);
    wchk(4'd3, 1'b0);
    // dropping the request mid-delay must cancel the trap
    set_cfg(64'h0000_0000_2000_0000);
    wait_req <= 1'b1;
    repeat (100) @(posedge clk_sys);
    wait_req <= 1'b0;
    n = 0;
    repeat (400) begin
      @(posedge clk_sys);
      #1;
      if (wait_trap !== 1'b0) n++;
    end
    chk("wait_cancel", 0, n);
    finish_test();
  end
endmodule
